// >>> hw/fdc_detect_irq.sv
// Control, status and interrupt logic of the demodulator ring and carrier detectors
`timescale 1ns/10ps
`default_nettype none
module fdc_detect_irq (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] bus_addr,
  input wire logic [3:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [3:0] bus_rdata,
  input wire logic ring_detect_input,
  input wire logic carrier_detect_input,
  input wire logic demod_data,
  input wire logic serial2_receive_pin,
  input wire logic serial2_pin_select,
  input wire logic cpu_irq_enable,
  output logic demod_power_on,
  output logic serial2_rx_data,
  output logic port3_serial_enable,
  output logic cpu_irq
);
  fdc_pkg::fdc_state_t s;
  fdc_pkg::fdc_state_t next_s;
  fdc_pkg::fdc_bus_req_t req;
  fdc_pkg::fdc_pair_t edge_ev;

  assign req = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};

  function automatic logic fdc_hit(input logic [15:0] a, input logic [15:0] r, input logic en);
    fdc_hit = en && (a == r);
  endfunction : fdc_hit

  function automatic logic fdc_edge(input logic cur, input logic prv, input logic fall);
    fdc_edge = fall ? (prv && !cur) : (!prv && cur);
  endfunction : fdc_edge

  always_comb begin
    next_s = s;
    // Two-stage sync then sample compare
    next_s.sync1 = '{ring: ring_detect_input, carrier: carrier_detect_input};
    next_s.sync2 = s.sync1;
    next_s.prev = s.sync2;
    // No edges until the pipeline is filled, else a high input after reset looks like a rise
    next_s.warm = (s.warm == fdc_pkg::WARM_DONE) ? s.warm : s.warm + 2'h1;
    edge_ev.ring = (s.warm == fdc_pkg::WARM_DONE)
      && fdc_edge(s.sync2.ring, s.prev.ring, s.edge_sel.ring);
    edge_ev.carrier = (s.warm == fdc_pkg::WARM_DONE)
      && fdc_edge(s.sync2.carrier, s.prev.carrier, s.edge_sel.carrier);
    if (fdc_hit(req.addr, fdc_pkg::ADDR_CTRL_STATUS, req.wr)) begin
      next_s.power_on = req.wdata[fdc_pkg::BIT_POWER_ON];
    end
    if (fdc_hit(req.addr, fdc_pkg::ADDR_EDGE_SELECT, req.wr)) begin
      next_s.edge_sel.ring = req.wdata[fdc_pkg::BIT_RING];
      next_s.edge_sel.carrier = req.wdata[fdc_pkg::BIT_CARRIER];
    end
    if (fdc_hit(req.addr, fdc_pkg::ADDR_IRQ_MASK, req.wr)) begin
      next_s.mask.ring = req.wdata[fdc_pkg::BIT_RING];
      next_s.mask.carrier = req.wdata[fdc_pkg::BIT_CARRIER];
    end
    if (fdc_hit(req.addr, fdc_pkg::ADDR_IRQ_FLAGS, req.wr)) begin
      if (req.wdata[fdc_pkg::BIT_RING]) begin
        next_s.flag.ring = 1'b0;
      end
      if (req.wdata[fdc_pkg::BIT_CARRIER]) begin
        next_s.flag.carrier = 1'b0;
      end
    end
    // Set after clear so an edge wins
    if (edge_ev.ring) begin
      next_s.flag.ring = 1'b1;
    end
    if (edge_ev.carrier) begin
      next_s.flag.carrier = 1'b1;
    end
    next_s.rdata = fdc_pkg::READ_UNMAPPED;
    if (fdc_hit(req.addr, fdc_pkg::ADDR_CTRL_STATUS, req.rd)) begin
      next_s.rdata[fdc_pkg::BIT_POWER_ON] = s.power_on;
      next_s.rdata[fdc_pkg::BIT_RING] = s.sync2.ring;
      next_s.rdata[fdc_pkg::BIT_CARRIER] = s.sync2.carrier;
    end
    if (fdc_hit(req.addr, fdc_pkg::ADDR_EDGE_SELECT, req.rd)) begin
      next_s.rdata[fdc_pkg::BIT_RING] = s.edge_sel.ring;
      next_s.rdata[fdc_pkg::BIT_CARRIER] = s.edge_sel.carrier;
    end
    if (fdc_hit(req.addr, fdc_pkg::ADDR_IRQ_MASK, req.rd)) begin
      next_s.rdata[fdc_pkg::BIT_RING] = s.mask.ring;
      next_s.rdata[fdc_pkg::BIT_CARRIER] = s.mask.carrier;
    end
    if (fdc_hit(req.addr, fdc_pkg::ADDR_IRQ_FLAGS, req.rd)) begin
      next_s.rdata[fdc_pkg::BIT_RING] = s.flag.ring;
      next_s.rdata[fdc_pkg::BIT_CARRIER] = s.flag.carrier;
    end
    next_s.irq = cpu_irq_enable &&
      ((s.flag.ring && s.mask.ring) || (s.flag.carrier && s.mask.carrier));
    next_s.serial2_rx = s.power_on ? demod_data : serial2_receive_pin;
    next_s.port3_serial_en = !s.power_on && serial2_pin_select;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign bus_rdata = s.rdata;
  assign demod_power_on = s.power_on;
  assign serial2_rx_data = s.serial2_rx;
  assign port3_serial_enable = s.port3_serial_en;
  assign cpu_irq = s.irq;

  a_ring_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
    edge_ev.ring |=> s.flag.ring) else $error("ring flag not set");
  a_carrier_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
    edge_ev.carrier |=> s.flag.carrier) else $error("carrier flag not set");
  a_flag_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (bus_wr && bus_addr == fdc_pkg::ADDR_IRQ_FLAGS && bus_wdata[fdc_pkg::BIT_RING]
     && !edge_ev.ring) |=> !s.flag.ring) else $error("ring flag not cleared");
  a_flag_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (s.flag.ring && !(bus_wr && bus_addr == fdc_pkg::ADDR_IRQ_FLAGS
     && bus_wdata[fdc_pkg::BIT_RING])) |=> s.flag.ring) else $error("ring flag lost");
  a_ring_rise: assert property (@(posedge clk) disable iff (!rst_n)
    (s.warm == fdc_pkg::WARM_DONE && !s.edge_sel.ring && $rose(s.sync2.ring)) |-> edge_ev.ring)
    else $error("ring rising edge missed");
  a_ring_fall: assert property (@(posedge clk) disable iff (!rst_n)
    (s.warm == fdc_pkg::WARM_DONE && s.edge_sel.ring && $fell(s.sync2.ring)) |-> edge_ev.ring)
    else $error("ring falling edge missed");
  a_carrier_fall: assert property (@(posedge clk) disable iff (!rst_n)
    (s.warm == fdc_pkg::WARM_DONE && s.edge_sel.carrier && $fell(s.sync2.carrier))
    |-> edge_ev.carrier) else $error("carrier falling edge missed");
  a_warm_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    (s.warm != fdc_pkg::WARM_DONE) |-> (!edge_ev.ring && !edge_ev.carrier))
    else $error("edge during warm-up");
  sequence carrier_clear_req;
    bus_wr && bus_addr == fdc_pkg::ADDR_IRQ_FLAGS && bus_wdata[fdc_pkg::BIT_CARRIER]
      && !edge_ev.carrier;
  endsequence
  a_carrier_clear: assert property (@(posedge clk) disable iff (!rst_n)
    carrier_clear_req |=> !s.flag.carrier) else $error("carrier flag not cleared");
  a_irq_raise: assert property (@(posedge clk) disable iff (!rst_n)
    (cpu_irq_enable && s.flag.carrier && s.mask.carrier) |=> cpu_irq)
    else $error("irq not raised");
  a_port3_free: assert property (@(posedge clk) disable iff (!rst_n)
    (!s.power_on && serial2_pin_select) |=> port3_serial_enable)
    else $error("port3 not released");
  a_status_read: assert property (@(posedge clk) disable iff (!rst_n)
    (bus_rd && bus_addr == fdc_pkg::ADDR_CTRL_STATUS) |=>
    bus_rdata[fdc_pkg::BIT_RING] == $past(s.sync2.ring))
    else $error("ring status misread");
  a_irq_gate: assert property (@(posedge clk) disable iff (!rst_n)
    cpu_irq |-> $past(cpu_irq_enable) && (($past(s.flag.ring) && $past(s.mask.ring))
    || ($past(s.flag.carrier) && $past(s.mask.carrier)))) else $error("spurious irq");
  a_rx_route: assert property (@(posedge clk) disable iff (!rst_n)
    $past(s.power_on) |-> serial2_rx_data == $past(demod_data))
    else $error("receive not from demodulator");
  a_port3_gpio: assert property (@(posedge clk) disable iff (!rst_n)
    $past(s.power_on) |-> !port3_serial_enable) else $error("port3 taken while on");
  a_power_write: assert property (@(posedge clk) disable iff (!rst_n)
    (bus_wr && bus_addr == fdc_pkg::ADDR_CTRL_STATUS) |=>
    demod_power_on == $past(bus_wdata[fdc_pkg::BIT_POWER_ON]))
    else $error("power bit not written");
endmodule : fdc_detect_irq
`default_nettype wire

// >>> hw/fdc_pkg.sv
// Package of constants and types for the demodulator detect control block
package fdc_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 4;
  localparam logic [15:0] ADDR_CTRL_STATUS = 16'hFF66;
  localparam logic [15:0] ADDR_EDGE_SELECT = 16'hFF67;
  localparam logic [15:0] ADDR_IRQ_MASK = 16'hFFEA;
  localparam logic [15:0] ADDR_IRQ_FLAGS = 16'hFFFA;
  localparam int unsigned BIT_POWER_ON = 3;
  localparam int unsigned BIT_RING = 1;
  localparam int unsigned BIT_CARRIER = 0;
  localparam logic [3:0] REG_RESET = 4'h0;
  localparam logic [3:0] READ_UNMAPPED = 4'h0;
  // Cycles until the sync pipeline and the previous sample hold real input levels
  localparam logic [1:0] WARM_DONE = 2'h3;

  typedef struct packed {
    logic ring;
    logic carrier;
  } fdc_pair_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [3:0] wdata;
    logic wr;
    logic rd;
  } fdc_bus_req_t;

  typedef struct packed {
    logic power_on;
    fdc_pair_t edge_sel;
    fdc_pair_t mask;
    fdc_pair_t flag;
    fdc_pair_t sync1;
    fdc_pair_t sync2;
    fdc_pair_t prev;
    logic [3:0] rdata;
    logic irq;
    logic serial2_rx;
    logic port3_serial_en;
    logic [1:0] warm;
  } fdc_state_t;
endpackage : fdc_pkg

// >>> tb/fdc_cpu_model.sv
// CPU interrupt acceptance model standing beyond the detect block
`timescale 1ns/10ps
`default_nettype none
module fdc_cpu_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cpu_irq,
  input wire logic ei,
  output logic cpu_irq_enable,
  output logic [3:0] accepted
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_irq_enable <= 1'b0;
      accepted <= 4'h0;
    end else if (cpu_irq && cpu_irq_enable) begin
      // Taking an interrupt drops the global enable
      cpu_irq_enable <= 1'b0;
      accepted <= accepted + 4'h1;
    end else if (ei) begin
      // Re-enabled on an ei pulse, whether or not the flag has been cleared
      cpu_irq_enable <= 1'b1;
    end
  end
endmodule : fdc_cpu_model
`default_nettype wire

// >>> tb/fdc_detect_irq_tb.sv
// Testbench of the demodulator detect control block
`timescale 1ns/10ps
`default_nettype none
module fdc_detect_irq_tb;
  logic clk = 1'b0, rst_n = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0, ring = 1'b1, carrier = 1'b0;
  logic demod_data = 1'b1, rx_pin = 1'b0, pin_sel = 1'b1, ei = 1'b0, irq_en, cpu_irq;
  logic power_on, rx_data, p3_en;
  logic [15:0] bus_addr = 16'h0000;
  logic [3:0] bus_wdata = 4'h0, bus_rdata, accepted, exp_acc;
  logic [1:0] es;
  int n_errors = 0, checked = 0;
  fdc_detect_irq i_fdc_detect_irq (.clk(clk), .rst_n(rst_n), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .ring_detect_input(ring), .carrier_detect_input(carrier), .demod_data(demod_data),
    .serial2_receive_pin(rx_pin), .serial2_pin_select(pin_sel), .cpu_irq_enable(irq_en),
    .demod_power_on(power_on), .serial2_rx_data(rx_data), .port3_serial_enable(p3_en),
    .cpu_irq(cpu_irq));
  fdc_cpu_model i_fdc_cpu_model (.clk(clk), .rst_n(rst_n), .cpu_irq(cpu_irq), .ei(ei),
    .cpu_irq_enable(irq_en), .accepted(accepted));
  initial begin
    forever #20 clk = ~clk;
  end
  task chk(input logic [3:0] got, input logic [3:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [15:0] a, input logic [3:0] d);
    @(posedge clk) {bus_wr, bus_addr, bus_wdata} <= {1'b1, a, d};
    @(posedge clk) bus_wr <= 1'b0;
  endtask : wr
  task rd(input logic [15:0] a, input logic [3:0] e);
    @(posedge clk) {bus_rd, bus_addr} <= {1'b1, a};
    @(posedge clk) bus_rd <= 1'b0;
    #1 chk(bus_rdata, e);
  endtask : rd
  task print_verdict;
    if (n_errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(16'hFF66, 4'h2);
    rd(16'hFF67, 4'h0);
    rd(16'hFFEA, 4'h0);
    rd(16'hFF00, 4'h0);
    wr(16'hFFFA, 4'hF);
    rd(16'hFFFA, 4'h0);
    wr(16'hFF66, 4'hF);
    rd(16'hFF66, 4'hA);
    repeat (2) @(posedge clk);
    chk({power_on, p3_en, rx_data, 1'b0}, 4'hA);
    wr(16'hFF66, 4'h0);
    rd(16'hFF66, 4'h2);
    repeat (2) @(posedge clk);
    chk({power_on, p3_en, rx_data, 1'b0}, 4'h4);
    @(posedge clk) ei <= 1'b1;
    @(posedge clk) ei <= 1'b0;
    exp_acc = 4'h0;
    for (int i = 0; i < 4; i++) begin
      es = i[1:0];
      wr(16'hFF67, {2'b00, es});
      wr(16'hFFEA, {2'b00, es});
      rd(16'hFF67, {2'b00, es});
      rd(16'hFFEA, {2'b00, es});
      @(posedge clk) {ring, carrier} <= {~ring, ~carrier};
      repeat (6) @(posedge clk);
      rd(16'hFFFA, {2'b00, ring ^ es[1], carrier ^ es[0]});
      rd(16'hFF66, {2'b00, ring, carrier});
      if ((es & {ring ^ es[1], carrier ^ es[0]}) != 2'b00) exp_acc = exp_acc + 4'h1;
      chk(accepted, exp_acc);
      wr(16'hFFFA, 4'h1);
      rd(16'hFFFA, {2'b00, ring ^ es[1], 1'b0});
      wr(16'hFFFA, 4'hF);
      rd(16'hFFFA, 4'h0);
      @(posedge clk) ei <= 1'b1;
      @(posedge clk) ei <= 1'b0;
    end
    repeat (3) @(posedge clk);
    chk(accepted, exp_acc);
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(16'hFF66, {2'b00, ring, 1'b0});
    rd(16'hFF67, 4'h0);
    rd(16'hFFEA, 4'h0);
    rd(16'hFFFA, 4'h0);
    chk(accepted, 4'h0);
    print_verdict();
  end
endmodule : fdc_detect_irq_tb
`default_nettype wire
